// ### hdl/regulator_mode_control.sv
// Control logic for one low-voltage buck and four linear regulators.
// Assumes straps stable from reset; pins asynchronous; one 250 MHz clock.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module regulator_mode_control (
  input  wire logic                                        ref_clk,
  input  wire logic                                        rst_n,
  input  wire logic [7:0]                                  reg_addr,
  input  wire logic [31:0]                                 reg_wdata,
  input  wire logic                                        reg_wr,
  input  wire logic                                        reg_rd,
  output logic      [31:0]                                 reg_rdata,
  input  wire logic                                        standby_req,
  input  wire logic                                        buck_in_sequence,
  input  wire logic [regulator_mode_control_pkg::NUM_LINREG-1:0] linreg_in_sequence,
  input  wire logic [1:0]                                  buck_inductor_sel,
  input  wire logic [regulator_mode_control_pkg::NUM_LINREG-1:0] linreg_switch_mode_cfg,
  input  wire logic [15:0]                                 linreg_default_voltage,
  input  wire logic                                        second_linreg_enable_pin,
  input  wire logic                                        volt_select_pin,
  output logic      [1:0]                                  buck_mode,
  output logic      [1:0]                                  buck_current_limit,
  output logic      [2:0]                                  buck_phase,
  output logic      [1:0]                                  buck_inductor,
  output logic                                             buck_transition_busy,
  output logic      [regulator_mode_control_pkg::NUM_LINREG-1:0] linreg_on,
  output logic      [regulator_mode_control_pkg::NUM_LINREG-1:0] linreg_pulldown,
  output logic      [regulator_mode_control_pkg::NUM_LINREG-1:0] linreg_switch_enable,
  output logic      [15:0]                                 linreg_voltage,
  output logic                                             irq_out_n
);
  import regulator_mode_control_pkg::*;

  power_state_e            state;
  logic [1:0]              buck_run_mode_sel;
  logic [1:0]              buck_standby_mode_sel;
  logic [1:0]              buck_current_limit_sel;
  logic [2:0]              buck_phase_sel;
  logic [NUM_LINREG-1:0]   linreg_run_enable;
  logic [NUM_LINREG-1:0]   linreg_standby_enable;
  logic [15:0]             linreg_run_voltage;
  logic [15:0]             linreg_standby_voltage;
  logic                    hw_ctrl;
  logic                    buck_mode_change_irq;
  logic                    irq_mask;
  logic [1:0]              mode_applied;
  logic [1:0]              mode_target;
  logic [CNT_W-1:0]        wait_cnt;
  logic [2:0]              pin_en_sync;
  logic [2:0]              pin_vs_sync;
  logic                    mode_change;
  logic                    wr_buck;
  logic                    wr_en;
  logic                    wr_runv;
  logic                    wr_stbv;
  logic                    wr_stat;
  logic                    wr_mask;
  logic                    wr_hw;
  logic [NUM_LINREG-1:0]   en_now;

  assign wr_buck = reg_wr && (reg_addr == ADDR_BUCK_CTRL);
  assign wr_en   = reg_wr && (reg_addr == ADDR_LINREG_EN);
  assign wr_runv = reg_wr && (reg_addr == ADDR_LINREG_RUNV);
  assign wr_stbv = reg_wr && (reg_addr == ADDR_LINREG_STBV);
  assign wr_stat = reg_wr && (reg_addr == ADDR_IRQ_STATUS);
  assign wr_mask = reg_wr && (reg_addr == ADDR_IRQ_MASK);
  assign wr_hw   = reg_wr && (reg_addr == ADDR_HW_CTRL);

  // Power state: leaves reset into run, then follows the standby request
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_RESET;
    end else begin
      unique case (state)
        ST_RESET:   state <= ST_RUN;
        ST_RUN:     state <= standby_req ? ST_STANDBY : ST_RUN;
        ST_STANDBY: state <= standby_req ? ST_STANDBY : ST_RUN;
        default:    state <= ST_RESET;
      endcase
    end
  end

  // Pin synchronisers for hardware control of the second regulator
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_en_sync <= 3'h0;
      pin_vs_sync <= 3'h0;
    end else begin
      pin_en_sync <= {pin_en_sync[1:0], second_linreg_enable_pin};
      pin_vs_sync <= {pin_vs_sync[1:0], volt_select_pin};
    end
  end

  // Buck configuration fields
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      buck_run_mode_sel      <= MODE_OFF;
      buck_standby_mode_sel  <= MODE_OFF;
      buck_current_limit_sel <= ILIM_RESET;
      buck_phase_sel         <= PHASE_ZERO_DEG;                            // [RL7]
    end else if (state == ST_RESET) begin
      buck_run_mode_sel      <= buck_in_sequence ? MODE_AUTOSKIP : MODE_OFF; // [RL1]
      buck_standby_mode_sel  <= buck_in_sequence ? MODE_AUTOSKIP : MODE_OFF; // [RL1]
    end else if (wr_buck) begin
      buck_run_mode_sel      <= reg_wdata[RUN_MODE_LSB +: 2];
      buck_standby_mode_sel  <= reg_wdata[STBY_MODE_LSB +: 2];
      buck_current_limit_sel <= reg_wdata[ILIM_LSB +: 2];                  // [RL4]
      buck_phase_sel         <= reg_wdata[PHASE_LSB +: 3];                 // [RL5] [RL6]
    end
  end

  // Target mode follows state; voltage is untouched by state changes
  assign mode_target = (state == ST_STANDBY) ? buck_standby_mode_sel :
                       (state == ST_RUN)     ? buck_run_mode_sel : MODE_OFF; // [RL3]

  // Applied mode with PFM to PWM hold-off
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_applied <= MODE_OFF;
      wait_cnt     <= '0;
    end else if (wait_cnt != '0) begin
      wait_cnt <= wait_cnt - 1'b1;
      if (wait_cnt == CNT_W'(1)) begin
        mode_applied <= MODE_PWM;                                          // [RL9]
      end
    end else if (mode_target != mode_applied) begin
      if (mode_applied == MODE_PFM && mode_target == MODE_PWM) begin
        wait_cnt <= CNT_W'(PFM_PWM_CYC);                                   // [RL9]
      end else begin
        mode_applied <= mode_target;
      end
    end
  end

  assign mode_change = (wait_cnt == '0) && (mode_target != mode_applied) &&
                       !(mode_applied == MODE_PFM && mode_target == MODE_PWM) ||
                       (wait_cnt == CNT_W'(1));

  // Interrupt status and mask; a new event wins over a clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      buck_mode_change_irq <= 1'b0;
    end else if (mode_change) begin
      buck_mode_change_irq <= 1'b1;                                        // [RL2]
    end else if (wr_stat && reg_wdata[0]) begin
      buck_mode_change_irq <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_mask <= MASK_RESET;
      hw_ctrl  <= 1'b0;
    end else begin
      if (wr_mask) begin
        irq_mask <= reg_wdata[0];
      end
      if (wr_hw) begin
        hw_ctrl <= reg_wdata[0];
      end
    end
  end

  assign irq_out_n = !(buck_mode_change_irq && !irq_mask);                 // [RL2]

  // Linear regulator enables and voltage fields
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      linreg_run_enable     <= '0;                                         // [RL10]
      linreg_standby_enable <= '0;                                         // [RL11]
    end else if (state == ST_RESET) begin
      linreg_run_enable     <= linreg_in_sequence;                         // [RL10]
      linreg_standby_enable <= linreg_in_sequence;                         // [RL11]
    end else if (wr_en) begin
      linreg_run_enable     <= reg_wdata[NUM_LINREG-1:0];
      linreg_standby_enable <= reg_wdata[STBY_EN_LSB +: NUM_LINREG];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      linreg_run_voltage     <= 16'h0000;
      linreg_standby_voltage <= 16'h0000;
    end else if (state == ST_RESET) begin
      linreg_run_voltage     <= linreg_default_voltage;                    // [RL15]
      linreg_standby_voltage <= linreg_default_voltage;                    // [RL15]
    end else begin
      if (wr_runv) begin
        linreg_run_voltage <= reg_wdata[15:0];                             // [RL13]
      end
      if (wr_stbv) begin
        linreg_standby_voltage <= reg_wdata[15:0];                         // [RL13]
      end
    end
  end

  // Per-regulator operation mode and voltage selection
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINREG; gi++) begin : g_linreg
      logic en_sw;
      logic vs_stby;
      if (gi == 1) begin : g_hw
        assign en_sw   = hw_ctrl ? pin_en_sync[2] :
                         (state == ST_STANDBY) ? linreg_standby_enable[gi] : linreg_run_enable[gi]; // [RL16]
        assign vs_stby = hw_ctrl ? pin_vs_sync[2] : (state == ST_STANDBY);                          // [RL16]
      end else begin : g_sw
        assign en_sw   = (state == ST_STANDBY) ? linreg_standby_enable[gi] : linreg_run_enable[gi]; // [RL14]
        assign vs_stby = (state == ST_STANDBY);
      end
      assign en_now[gi] = en_sw && (state != ST_RESET);
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          linreg_on[gi]            <= 1'b0;
          linreg_pulldown[gi]      <= 1'b1;
          linreg_switch_enable[gi] <= 1'b0;
          linreg_voltage[gi*4 +: 4] <= 4'h0;
        end else begin
          linreg_pulldown[gi]      <= !en_now[gi];                                            // [RL12]
          linreg_on[gi]            <= en_now[gi] && !linreg_switch_mode_cfg[gi];               // [RL12]
          linreg_switch_enable[gi] <= en_now[gi] && linreg_switch_mode_cfg[gi];                // [RL17]
          linreg_voltage[gi*4 +: 4] <= vs_stby ? linreg_standby_voltage[gi*4 +: 4]
                                               : linreg_run_voltage[gi*4 +: 4];                // [RL14]
        end
      end
    end
  endgenerate

  // Buck outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      buck_mode            <= MODE_OFF;
      buck_current_limit   <= ILIM_RESET;
      buck_phase           <= PHASE_ZERO_DEG;
      buck_inductor        <= 2'h0;
      buck_transition_busy <= 1'b0;
    end else begin
      buck_mode            <= mode_applied;
      buck_current_limit   <= buck_current_limit_sel;                      // [RL4]
      buck_phase           <= buck_phase_sel;                              // [RL5]
      buck_inductor        <= (buck_inductor_sel == INDUCTOR_RSVD) ? 2'h0 : buck_inductor_sel; // [RL8]
      buck_transition_busy <= (wait_cnt != '0);
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_BUCK_CTRL:   reg_rdata <= {23'h0, buck_phase_sel, buck_current_limit_sel,
                                        buck_standby_mode_sel, buck_run_mode_sel};
        ADDR_LINREG_EN:   reg_rdata <= {24'h0, linreg_standby_enable, linreg_run_enable};
        ADDR_LINREG_RUNV: reg_rdata <= {16'h0, linreg_run_voltage};
        ADDR_LINREG_STBV: reg_rdata <= {16'h0, linreg_standby_voltage};
        ADDR_IRQ_STATUS:  reg_rdata <= {31'h0, buck_mode_change_irq};
        ADDR_IRQ_MASK:    reg_rdata <= {31'h0, irq_mask};
        ADDR_BUCK_STATUS: reg_rdata <= {25'h0, (wait_cnt != '0), buck_inductor_sel, state, mode_applied};
        ADDR_HW_CTRL:     reg_rdata <= {31'h0, hw_ctrl};
        default:          reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// ### hdl/regulator_mode_control_pkg.sv
// Constants, register map and encodings for the regulator mode control block.
// Assumes a single 250 MHz clock and a plain one-cycle strobe register port.
// Operation
// RL1: Buck run and standby modes load autoskip if sequenced, else off.
// RL2: Any buck mode change sets a sticky flag driving the low-active interrupt.
// RL3: Buck voltage stays fixed across run/standby; only mode fields enable it.
// RL4: Two-bit current-limit code selects buck peak current limit.
// RL5: Three-bit phase code selects shift in 45 degree steps.
// RL6: Phase codes ascend from 45 degrees; code 111 means 0 degrees.
// RL7: Phase resets to 0 degrees and stays writable afterwards.
// RL8: Strapped inductor code selects 1.0, 0.47 or 1.5 uH; 11 reserved.
// RL9: PFM to PWM change holds at least 10 us before completing.
// RL10: Each linear regulator has a run enable, sequenced-set else zero.
// RL11: Each linear regulator has a standby enable, sequenced-set else zero.
// RL12: Enable and switch-mode bit select off, regulate, or load switch.
// RL13: Four-bit code sets linear regulator output voltage per table.
// RL14: Run or standby voltage field applies according to present state.
// RL15: Default voltage code loads both run and standby fields at power up.
// RL16: Second regulator may take enable and voltage choice from pins.
// RL17: In load switch mode the enable opens and closes the switch.
package regulator_mode_control_pkg;

  localparam int            NUM_LINREG       = 4;
  localparam logic [7:0]    ADDR_BUCK_CTRL   = 8'h00;
  localparam logic [7:0]    ADDR_LINREG_EN   = 8'h04;
  localparam logic [7:0]    ADDR_LINREG_RUNV = 8'h08;
  localparam logic [7:0]    ADDR_LINREG_STBV = 8'h0C;
  localparam logic [7:0]    ADDR_IRQ_STATUS  = 8'h10;
  localparam logic [7:0]    ADDR_IRQ_MASK    = 8'h14;
  localparam logic [7:0]    ADDR_BUCK_STATUS = 8'h18;
  localparam logic [7:0]    ADDR_HW_CTRL     = 8'h1C;

  // Buck control fields
  localparam int            RUN_MODE_LSB     = 0;
  localparam int            STBY_MODE_LSB    = 2;
  localparam int            ILIM_LSB         = 4;
  localparam int            PHASE_LSB        = 6;
  // Linear enable register: run bits 3:0, standby bits 7:4
  localparam int            STBY_EN_LSB      = 4;

  localparam logic [1:0]    MODE_OFF         = 2'h0;
  localparam logic [1:0]    MODE_PWM         = 2'h1;
  localparam logic [1:0]    MODE_PFM         = 2'h2;
  localparam logic [1:0]    MODE_AUTOSKIP    = 2'h3;
  localparam logic [1:0]    ILIM_RESET       = 2'h0;
  localparam logic [2:0]    PHASE_ZERO_DEG   = 3'h7;
  localparam logic [1:0]    INDUCTOR_RSVD    = 2'h3;
  localparam logic [0:0]    MASK_RESET       = 1'h1;

  localparam int            CLK_MHZ          = 250;
  localparam int            PFM_PWM_US       = 10;
  localparam int            PFM_PWM_CYC      = PFM_PWM_US * CLK_MHZ;
  localparam int            CNT_W            = 12;

  typedef enum logic [1:0] {
    ST_RESET   = 2'b00,
    ST_RUN     = 2'b01,
    ST_STANDBY = 2'b10
  } power_state_e;

endpackage

// ### sim/regulator_mode_control_monitor.sv
// Concurrent checks on the regulator mode control top-level ports.
// Assumes a bind to the top module; one clock, synchronous low reset.
`timescale 1ns/1ps
module regulator_mode_control_monitor (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        standby_req,
  input wire logic        buck_in_sequence,
  input wire logic [3:0]  linreg_in_sequence,
  input wire logic [1:0]  buck_inductor_sel,
  input wire logic [3:0]  linreg_switch_mode_cfg,
  input wire logic [15:0] linreg_default_voltage,
  input wire logic [1:0]  buck_mode,
  input wire logic [1:0]  buck_current_limit,
  input wire logic [2:0]  buck_phase,
  input wire logic [1:0]  buck_inductor,
  input wire logic        buck_transition_busy,
  input wire logic [3:0]  linreg_on,
  input wire logic [3:0]  linreg_pulldown,
  input wire logic [3:0]  linreg_switch_enable,
  input wire logic [15:0] linreg_voltage
);
  import regulator_mode_control_pkg::*;
  // Hold must cover the full PFM to PWM count
  localparam int HOLD_MIN = PFM_PWM_CYC;
  logic [11:0] hold_cnt;
  logic [2:0]  wr_phase;
  logic [1:0]  wr_ilim;
  assign wr_phase = reg_wdata[8:6];
  assign wr_ilim  = reg_wdata[5:4];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Length of the current PFM to PWM hold
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !buck_transition_busy) hold_cnt <= 12'h000;
    else if (hold_cnt != 12'hFFF) hold_cnt <= hold_cnt + 12'h001;
  end
  phase_reset_a: assert property ($rose(rst_n) |-> buck_phase == PHASE_ZERO_DEG)
    else $error("phase not zero degrees after reset");
  mode_default_a: assert property ($rose(rst_n) && !standby_req |-> ##4
    buck_mode == (buck_in_sequence ? MODE_AUTOSKIP : MODE_OFF)) else $error("buck default mode wrong");
  enable_default_a: assert property ($rose(rst_n) && !standby_req |-> ##4
    linreg_pulldown == ~linreg_in_sequence) else $error("linear default enable wrong");
  volt_default_a: assert property ($rose(rst_n) |-> ##4 linreg_voltage == linreg_default_voltage)
    else $error("default voltage not loaded");
  inductor_map_a: assert property ($rose(rst_n) |-> ##4
    buck_inductor == ((buck_inductor_sel == INDUCTOR_RSVD) ? 2'h0 : buck_inductor_sel))
    else $error("inductor select wrong");
  mode_split_a: assert property ((linreg_pulldown ^ (linreg_on | linreg_switch_enable)) == 4'hF)
    else $error("linear output mode inconsistent");
  switch_strap_a: assert property ((linreg_switch_enable & ~linreg_switch_mode_cfg) == 4'h0)
    else $error("switch enabled without switch strap");
  buck_write_a: assert property (reg_wr && reg_addr == ADDR_BUCK_CTRL ##1 !reg_wr |-> ##1
    buck_phase == $past(wr_phase, 2) && buck_current_limit == $past(wr_ilim, 2))
    else $error("phase or current limit not applied");
  pwm_entry_a: assert property ($rose(buck_transition_busy) |-> buck_mode == MODE_PFM)
    else $error("hold started outside PFM");
  pwm_hold_a: assert property ($fell(buck_transition_busy) |-> hold_cnt >= HOLD_MIN)
    else $error("PFM to PWM hold too short");
  pwm_done_a: assert property ($fell(buck_transition_busy) |-> ##[0:2] buck_mode == MODE_PWM)
    else $error("PWM not applied after hold");
endmodule

// ### sim/regulator_pin_host.sv
// Host-side logic that drives the second regulator's control pins.
// Assumes the block synchronises both pins; they change off the clock edge.
`timescale 1ns/1ps
module regulator_pin_host (
  input  wire logic ref_clk,
  input  wire logic en_req,
  input  wire logic sel_req,
  output logic      second_linreg_enable_pin,
  output logic      volt_select_pin
);
  // Both pins always driven, never left floating
  initial begin
    second_linreg_enable_pin = 1'b0;
    volt_select_pin          = 1'b0;
  end
  always @(posedge ref_clk) begin
    #1.3;
    second_linreg_enable_pin = en_req;
    volt_select_pin          = sel_req;
  end
endmodule

// ### sim/regulator_mode_control_tb.sv
// Self-checking bench for the regulator mode control block.
// Assumes the package, the pin host model and the checker are compiled first.
`timescale 1ns/1ps
bind regulator_mode_control regulator_mode_control_monitor mon (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .standby_req, .buck_in_sequence, .linreg_in_sequence, .buck_inductor_sel, .linreg_switch_mode_cfg,
  .linreg_default_voltage, .buck_mode, .buck_current_limit, .buck_phase, .buck_inductor,
  .buck_transition_busy, .linreg_on, .linreg_pulldown, .linreg_switch_enable, .linreg_voltage);
module regulator_mode_control_tb;
  import regulator_mode_control_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, standby_req = 1'b0;
  logic        buck_in_sequence = 1'b0, en_req = 1'b0, sel_req = 1'b0;
  logic        second_linreg_enable_pin, volt_select_pin, buck_transition_busy, irq_out_n;
  logic [1:0]  buck_inductor_sel = 2'h0;
  logic [1:0]  buck_mode, buck_current_limit, buck_inductor;
  logic [2:0]  buck_phase;
  logic [3:0]  linreg_in_sequence = 4'h0, linreg_switch_mode_cfg = 4'hA;
  logic [3:0]  linreg_on, linreg_pulldown, linreg_switch_enable;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] linreg_default_voltage = 16'h0000;
  logic [15:0] linreg_voltage;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  int          num_errors = 0, tests_run = 0, cycles = 0, n;

  regulator_mode_control uut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .standby_req, .buck_in_sequence, .linreg_in_sequence, .buck_inductor_sel, .linreg_switch_mode_cfg,
    .linreg_default_voltage, .second_linreg_enable_pin, .volt_select_pin, .buck_mode, .buck_current_limit,
    .buck_phase, .buck_inductor, .buck_transition_busy, .linreg_on, .linreg_pulldown,
    .linreg_switch_enable, .linreg_voltage, .irq_out_n);
  regulator_pin_host host (.ref_clk, .en_req, .sel_req, .second_linreg_enable_pin, .volt_select_pin);

  always #2 ref_clk = ~ref_clk;

  task automatic results;
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      results;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge ref_clk);
  endtask

  task automatic power_up(input logic b, input logic [3:0] l, input logic [1:0] ind, input logic [15:0] dv);
    rst_n                  <= 1'b0;
    buck_in_sequence       <= b;
    linreg_in_sequence     <= l;
    buck_inductor_sel      <= ind;
    linreg_default_voltage <= dv;
    settle(20);
    rst_n <= 1'b1;
    settle(6);
  endtask

  initial begin
    settle(1);
    power_up(1'b0, 4'h0, 2'h3, 16'h3C5A);
    rchk(ADDR_BUCK_CTRL, 32'h1C0);
    rchk(ADDR_LINREG_EN, 32'h0);
    rchk(ADDR_LINREG_STBV, 32'h3C5A);
    chk(buck_inductor, 2'h0);
    chk(linreg_pulldown, 4'hF);
    power_up(1'b1, 4'h5, 2'h2, 16'hF5D0);
    rchk(ADDR_BUCK_CTRL, 32'h1CF);
    rchk(ADDR_LINREG_EN, 32'h55);
    rchk(ADDR_LINREG_RUNV, 32'hF5D0);
    chk(linreg_voltage, 16'hF5D0);
    chk(linreg_on, 4'h5);
    chk(buck_inductor, 2'h2);
    rchk(ADDR_IRQ_MASK, 32'h1);
    rchk(8'h20, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_BUCK_CTRL, {23'h0, i[2:0], i[1:0], 4'hF});
      settle(2);
      chk(buck_phase, i[2:0]);
      chk(buck_current_limit, i[1:0]);
    end
    rchk(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0);
    chk(irq_out_n, 1'b1);
    wr(ADDR_BUCK_CTRL, 32'h1FD);
    settle(2);
    chk(buck_mode, MODE_PWM);
    chk(irq_out_n, 1'b0);
    rchk(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    chk(irq_out_n, 1'b1);
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_BUCK_CTRL, 32'h1FE);
    settle(2);
    chk(buck_mode, MODE_PFM);
    chk(irq_out_n, 1'b1);
    rchk(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0);
    wr(ADDR_BUCK_CTRL, 32'h1FD);
    settle(2);
    chk(buck_transition_busy, 1'b1);
    chk(buck_mode, MODE_PFM);
    n = 0;
    while (buck_transition_busy === 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n >= PFM_PWM_CYC, 1'b1);
    settle(3);
    chk(buck_mode, MODE_PWM);
    chk(irq_out_n, 1'b0);
    wr(ADDR_IRQ_STATUS, 32'h1);
    rchk(ADDR_BUCK_STATUS, 32'h25);
    wr(ADDR_LINREG_RUNV, 32'h1234);
    wr(ADDR_LINREG_STBV, 32'h9ABC);
    wr(ADDR_LINREG_EN, 32'hC3);
    settle(4);
    chk(linreg_voltage, 16'h1234);
    chk(linreg_pulldown, 4'hC);
    chk(linreg_switch_enable, 4'h2);
    standby_req <= 1'b1;
    settle(4);
    chk(linreg_voltage, 16'h9ABC);
    chk(linreg_pulldown, 4'h3);
    chk(linreg_switch_enable, 4'h8);
    chk(buck_mode, MODE_AUTOSKIP);
    standby_req <= 1'b0;
    settle(4);
    chk(buck_mode, MODE_PWM);
    wr(ADDR_HW_CTRL, 32'h1);
    en_req  <= 1'b1;
    sel_req <= 1'b1;
    settle(8);
    chk(linreg_voltage, 16'h12B4);
    chk(linreg_switch_enable, 4'h2);
    en_req  <= 1'b0;
    sel_req <= 1'b0;
    settle(8);
    chk(linreg_pulldown, 4'hE);
    chk(linreg_voltage, 16'h1234);
    chk(linreg_switch_enable, 4'h0);
    results;
  end
endmodule
